// ---- rtl/tmw_pkg.sv ----
package tmw_pkg;
   // Register byte addresses
   localparam logic [7:0]  TMW_OFS_CTRL_A  = 8'h80;
   localparam logic [7:0]  TMW_OFS_CTRL_B  = 8'h81;
   localparam logic [7:0]  TMW_OFS_CMP_A   = 8'h88;
   localparam logic [7:0]  TMW_OFS_CMP_B   = 8'h8A;
   localparam logic [7:0]  TMW_OFS_CAPT    = 8'h86;
   localparam logic [7:0]  TMW_OFS_COUNT   = 8'h84;
   localparam logic [7:0]  TMW_OFS_STATUS  = 8'h8C;
   // Word addresses chosen for the bus
   localparam logic [7:0]  TMW_ADR_CTRL_A  = 8'h00;
   localparam logic [7:0]  TMW_ADR_CTRL_B  = 8'h04;
   localparam logic [7:0]  TMW_ADR_CMP_A   = 8'h08;
   localparam logic [7:0]  TMW_ADR_CMP_B   = 8'h0C;
   localparam logic [7:0]  TMW_ADR_CAPT    = 8'h10;
   localparam logic [7:0]  TMW_ADR_COUNT   = 8'h14;
   localparam logic [7:0]  TMW_ADR_STATUS  = 8'h18;
   // Control A fields
   localparam int          TMW_CA_ACT_A    = 6;
   localparam int          TMW_CA_ACT_B    = 4;
   localparam int          TMW_CA_WGM_LO   = 0;
   // Control B fields
   localparam int          TMW_CB_FILT     = 7;
   localparam int          TMW_CB_EDGE     = 6;
   localparam int          TMW_CB_WGM_HI   = 3;
   localparam int          TMW_CB_CLK      = 0;
   localparam logic [7:0]  TMW_CB_WMASK    = 8'hDF;
   localparam logic [7:0]  TMW_CTRL_RST    = 8'h00;
   localparam logic [15:0] TMW_VAL_RST     = 16'h0000;
   // Counter extremes
   localparam logic [15:0] TMW_MAX         = 16'hFFFF;
   localparam logic [15:0] TMW_TOP8        = 16'h00FF;
   localparam logic [15:0] TMW_TOP9        = 16'h01FF;
   localparam logic [15:0] TMW_TOP10       = 16'h03FF;
   localparam logic [15:0] TMW_BOTTOM      = 16'h0000;
   // Prescaler taps
   localparam int          TMW_DIV8        = 8;
   localparam int          TMW_DIV64       = 64;
   localparam int          TMW_DIV256      = 256;
   localparam int          TMW_DIV1024     = 1024;
   localparam int          TMW_FILT_LEN    = 4;
   // Waveform families
   typedef enum logic [2:0] {
      TMW_WF_NORMAL = 3'b000,
      TMW_WF_CTC    = 3'b001,
      TMW_WF_FAST   = 3'b010,
      TMW_WF_PC     = 3'b011,
      TMW_WF_PFC    = 3'b100,
      TMW_WF_RSVD   = 3'b101
   } tmw_wave_e;
   // TOP source
   typedef enum logic [1:0] {
      TMW_TOP_FIX  = 2'b00,
      TMW_TOP_CMPA = 2'b01,
      TMW_TOP_CAPT = 2'b10
   } tmw_tops_e;
endpackage

// ---- rtl/tmw_out_unit.sv ----
`timescale 1ns/100ps
`default_nettype none
// One compare output channel: action decode per waveform family
module tmw_out_unit
   import tmw_pkg::*;
#(
   parameter bit              IS_CHAN_A = 1'b1
) (
   input  wire logic          clk_sys_i,
   input  wire logic          rst_i,
   input  wire logic          tick_i,
   input  wire logic [1:0]    action_i,
   input  wire logic [3:0]    mode_i,
   input  wire tmw_wave_e     wave_i,
   input  wire logic          match_i,
   input  wire logic          at_top_i,
   input  wire logic          at_bottom_i,
   input  wire logic          up_i,
   input  wire logic          cmp_is_top_i,
   output logic               pin_sel_o,
   output logic               wave_o
);
   logic wave_q;
   logic toggle_ok;

   // Code 01 toggles both channels in normal/CTC, only channel A in modes 14/15 and 9/11
   always_comb begin
      toggle_ok = 1'b0;
      case (wave_i)
         TMW_WF_NORMAL, TMW_WF_CTC: toggle_ok = 1'b1;
         TMW_WF_FAST: toggle_ok = IS_CHAN_A && (mode_i == 4'd14 || mode_i == 4'd15);
         TMW_WF_PC, TMW_WF_PFC: toggle_ok = IS_CHAN_A && (mode_i == 4'd9 || mode_i == 4'd11);
         default: toggle_ok = 1'b0;
      endcase
   end

   assign pin_sel_o = (action_i[1] || (action_i == 2'b01 && toggle_ok));
   assign wave_o    = wave_q;

   // Output register, updated on timer ticks only
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         wave_q <= 1'b0;
      end else if (tick_i) begin
         case (wave_i)
            TMW_WF_NORMAL, TMW_WF_CTC: begin
               if (match_i) begin
                  case (action_i)
                     2'b01:   wave_q <= ~wave_q;
                     2'b10:   wave_q <= 1'b0;
                     2'b11:   wave_q <= 1'b1;
                     default: wave_q <= wave_q;
                  endcase
               end
            end
            TMW_WF_FAST: begin
               if (action_i == 2'b01 && toggle_ok && match_i) begin
                  wave_q <= ~wave_q;
               end else if (action_i[1] && at_bottom_i) begin
                  wave_q <= ~action_i[0];
               end else if (action_i[1] && match_i && !(cmp_is_top_i && at_top_i)) begin
                  wave_q <= action_i[0];
               end
            end
            TMW_WF_PC, TMW_WF_PFC: begin
               if (action_i == 2'b01 && toggle_ok && match_i) begin
                  wave_q <= ~wave_q;
               end else if (action_i[1] && match_i) begin
                  wave_q <= up_i ? action_i[0] : ~action_i[0];
               end
            end
            default: wave_q <= wave_q;
         endcase
      end
   end
endmodule
`default_nettype wire

// ---- rtl/tmw_timer_top.sv ----
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Action 1x routes compare to pin, 01 only where it toggles
// - Non-PWM codes: off, toggle, clear, set
// - Fast toggle only channel A, 14/15
// - Fast: clear match set bottom, inverse
// - Fast: match at TOP ignored
// - Dual slope toggle only A, 9/11
// - Dual slope: level depends on direction
// - Mode selector from both control registers
// - Normal and CTC: immediate, overflow MAX
// - Phase correct: reload TOP, flag BOTTOM
// - Fast PWM: reload TOP, flag TOP
// - Phase-frequency: reload and flag BOTTOM
// - Control B layout, reserved bit reads 0
// - Clock source: stop, prescale, external edge
// - Capture edge: zero falling, one rising
// - Filter needs four equal samples
module tmw_timer_top
   import tmw_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic        rst_i,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        ext_clk_pin_i,
   input  wire logic        capture_pin_i,
   input  wire logic        port_a_data_i,
   input  wire logic        port_b_data_i,
   output logic             compare_out_a,
   output logic             compare_out_b,
   output logic             pin_sel_a_o,
   output logic             pin_sel_b_o,
   output logic             overflow_flag_o
);
   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [7:0]  ctrl_a_q;
   logic [7:0]  ctrl_b_q;
   logic [15:0] cmp_a_buf_q, cmp_b_buf_q;
   logic [15:0] cmp_a_q, cmp_b_q;
   logic [15:0] capture_value_q;
   logic [15:0] count_value_q;
   logic        up_q;
   logic        overflow_flag_q, capt_flag_q;
   logic [1:0]  chan_a_output_action, chan_b_output_action;
   logic [3:0]  waveform_mode_sel;
   logic [2:0]  clock_source_sel;
   logic        capture_filter_en, capture_edge_sel;

   assign chan_a_output_action = ctrl_a_q[TMW_CA_ACT_A +: 2];
   assign chan_b_output_action = ctrl_a_q[TMW_CA_ACT_B +: 2];
   assign waveform_mode_sel = {ctrl_b_q[TMW_CB_WGM_HI +: 2], ctrl_a_q[TMW_CA_WGM_LO +: 2]};
   assign clock_source_sel  = ctrl_b_q[TMW_CB_CLK +: 3];
   assign capture_filter_en = ctrl_b_q[TMW_CB_FILT];
   assign capture_edge_sel  = ctrl_b_q[TMW_CB_EDGE];

   ////////////////////////////////////////////////////////////////////////////
   // Mode decode
   tmw_wave_e   wave;
   tmw_tops_e   top_src;
   logic [15:0] fixed_top, top_val;

   always_comb begin
      wave      = TMW_WF_RSVD;
      top_src   = TMW_TOP_FIX;
      fixed_top = TMW_MAX;
      case (waveform_mode_sel)
         4'd0:  wave = TMW_WF_NORMAL;
         4'd4:  begin wave = TMW_WF_CTC;  top_src = TMW_TOP_CMPA; end
         4'd12: begin wave = TMW_WF_CTC;  top_src = TMW_TOP_CAPT; end
         4'd1:  begin wave = TMW_WF_PC;   fixed_top = TMW_TOP8;  end
         4'd2:  begin wave = TMW_WF_PC;   fixed_top = TMW_TOP9;  end
         4'd3:  begin wave = TMW_WF_PC;   fixed_top = TMW_TOP10; end
         4'd10: begin wave = TMW_WF_PC;   top_src = TMW_TOP_CAPT; end
         4'd11: begin wave = TMW_WF_PC;   top_src = TMW_TOP_CMPA; end
         4'd5:  begin wave = TMW_WF_FAST; fixed_top = TMW_TOP8;  end
         4'd6:  begin wave = TMW_WF_FAST; fixed_top = TMW_TOP9;  end
         4'd7:  begin wave = TMW_WF_FAST; fixed_top = TMW_TOP10; end
         4'd14: begin wave = TMW_WF_FAST; top_src = TMW_TOP_CAPT; end
         4'd15: begin wave = TMW_WF_FAST; top_src = TMW_TOP_CMPA; end
         4'd8:  begin wave = TMW_WF_PFC;  top_src = TMW_TOP_CAPT; end
         4'd9:  begin wave = TMW_WF_PFC;  top_src = TMW_TOP_CMPA; end
         default: wave = TMW_WF_RSVD;
      endcase
   end

   always_comb begin
      case (top_src)
         TMW_TOP_CMPA: top_val = cmp_a_q;
         TMW_TOP_CAPT: top_val = capture_value_q;
         default:      top_val = fixed_top;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [1:0] ext_sync_q, cap_sync_q;
   logic       ext_prev_q, cap_prev_q;

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         ext_sync_q <= 2'b00;
         cap_sync_q <= 2'b00;
         ext_prev_q <= 1'b0;
      end else begin
         ext_sync_q <= {ext_sync_q[0], ext_clk_pin_i};
         cap_sync_q <= {cap_sync_q[0], capture_pin_i};
         ext_prev_q <= ext_sync_q[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler; free running so taps stay aligned
   logic [9:0] presc_q;
   logic       tick;

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         presc_q <= 10'h000;
      end else begin
         presc_q <= presc_q + 10'h001;
      end
   end

   always_comb begin
      case (clock_source_sel)
         3'b001:  tick = 1'b1;
         3'b010:  tick = (presc_q[2:0] == 3'(TMW_DIV8 - 1));
         3'b011:  tick = (presc_q[5:0] == 6'(TMW_DIV64 - 1));
         3'b100:  tick = (presc_q[7:0] == 8'(TMW_DIV256 - 1));
         3'b101:  tick = (presc_q == 10'(TMW_DIV1024 - 1));
         3'b110:  tick = ext_prev_q && !ext_sync_q[1];
         3'b111:  tick = !ext_prev_q && ext_sync_q[1];
         default: tick = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Capture input filter and edge detect
   logic [TMW_FILT_LEN-1:0] filt_hist_q;
   logic                    filt_q, cap_in;
   logic                    capt_event;

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         filt_hist_q <= '0;
         filt_q      <= 1'b0;
      end else begin
         filt_hist_q <= {filt_hist_q[TMW_FILT_LEN-2:0], cap_sync_q[1]};
         if (&filt_hist_q) begin
            filt_q <= 1'b1;
         end else if (~|filt_hist_q) begin
            filt_q <= 1'b0;
         end
      end
   end

   assign cap_in = capture_filter_en ? filt_q : cap_sync_q[1];

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         cap_prev_q <= 1'b0;
      end else begin
         cap_prev_q <= cap_in;
      end
   end

   // edge polarity; capture off when it sets TOP
   assign capt_event = (top_src != TMW_TOP_CAPT) &&
                       (capture_edge_sel ? (cap_in && !cap_prev_q) : (!cap_in && cap_prev_q));

   ////////////////////////////////////////////////////////////////////////////
   // Counter
   logic at_top, at_bottom, match_a, match_b, cnt_wr;

   assign at_top    = (count_value_q == top_val);
   assign at_bottom = (count_value_q == TMW_BOTTOM);
   assign match_a   = (count_value_q == cmp_a_q);
   assign match_b   = (count_value_q == cmp_b_q);

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         count_value_q <= TMW_VAL_RST;
         up_q          <= 1'b1;
      end else if (cnt_wr) begin
         count_value_q <= w_data_q[15:0];
      end else if (tick) begin
         case (wave)
            TMW_WF_NORMAL: count_value_q <= count_value_q + 16'h0001;
            TMW_WF_CTC, TMW_WF_FAST: count_value_q <= at_top ? TMW_BOTTOM : count_value_q + 16'h0001;
            TMW_WF_PC, TMW_WF_PFC: begin
               if (up_q && at_top) begin
                  up_q          <= 1'b0;
                  count_value_q <= count_value_q - 16'h0001;
               end else if (!up_q && at_bottom) begin
                  up_q          <= 1'b1;
                  count_value_q <= count_value_q + 16'h0001;
               end else begin
                  count_value_q <= up_q ? count_value_q + 16'h0001 : count_value_q - 16'h0001;
               end
            end
            default: count_value_q <= count_value_q;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Compare reload and overflow point
   logic reload, ovf_set;

   always_comb begin
      case (wave)
         TMW_WF_NORMAL, TMW_WF_CTC: begin
            reload  = 1'b1;
            ovf_set = tick && (count_value_q == TMW_MAX);
         end
         TMW_WF_PC: begin
            reload  = tick && at_top;
            ovf_set = tick && at_bottom && !up_q;
         end
         TMW_WF_FAST: begin
            reload  = tick && at_top;
            ovf_set = tick && at_top;
         end
         TMW_WF_PFC: begin
            reload  = tick && at_bottom && !up_q;
            ovf_set = tick && at_bottom && !up_q;
         end
         default: begin
            reload  = 1'b0;
            ovf_set = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave, one write and one read at a time
   logic        aw_hold_q, w_hold_q;
   logic [7:0]  aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;
   logic        wr_fire, rd_fire;

   assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_fire       = aw_hold_q && w_hold_q;
   assign rd_fire       = s_axi_arvalid && s_axi_arready;
   assign cnt_wr        = wr_fire && aw_addr_q == TMW_ADR_COUNT && w_strb_q[1:0] == 2'b11;

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         aw_hold_q    <= 1'b0;
         w_hold_q     <= 1'b0;
         aw_addr_q    <= 8'h00;
         w_data_q     <= 32'h0000_0000;
         w_strb_q     <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_hold_q    <= 1'b0;
            w_hold_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_q > TMW_ADR_STATUS || aw_addr_q[1:0] != 2'b00) ? 2'b10 : 2'b00;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Control and compare buffers written by software
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         ctrl_a_q    <= TMW_CTRL_RST;
         ctrl_b_q    <= TMW_CTRL_RST;
         cmp_a_buf_q <= TMW_VAL_RST;
         cmp_b_buf_q <= TMW_VAL_RST;
      end else if (wr_fire && w_strb_q[0]) begin
         case (aw_addr_q)
            TMW_ADR_CTRL_A: ctrl_a_q <= w_data_q[7:0];
            TMW_ADR_CTRL_B: ctrl_b_q <= w_data_q[7:0] & TMW_CB_WMASK;
            TMW_ADR_CMP_A:  if (w_strb_q[1]) cmp_a_buf_q <= w_data_q[15:0];
            TMW_ADR_CMP_B:  if (w_strb_q[1]) cmp_b_buf_q <= w_data_q[15:0];
            default: ;
         endcase
      end
   end

   // Active compare values take the buffer at the mode's reload point
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         cmp_a_q <= TMW_VAL_RST;
         cmp_b_q <= TMW_VAL_RST;
      end else if (reload) begin
         cmp_a_q <= cmp_a_buf_q;
         cmp_b_q <= cmp_b_buf_q;
      end
   end

   // Capture register: software write or pin event
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         capture_value_q <= TMW_VAL_RST;
      end else if (wr_fire && aw_addr_q == TMW_ADR_CAPT && w_strb_q[1:0] == 2'b11) begin
         capture_value_q <= w_data_q[15:0];
      end else if (capt_event) begin
         capture_value_q <= count_value_q;
      end
   end

   // Sticky flags; a set in the clearing cycle wins
   logic flag_clr_wr;
   assign flag_clr_wr = wr_fire && aw_addr_q == TMW_ADR_STATUS && w_strb_q[0];

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         overflow_flag_q <= 1'b0;
         capt_flag_q     <= 1'b0;
      end else begin
         overflow_flag_q <= ovf_set || (overflow_flag_q && !(flag_clr_wr && w_data_q[0]));
         capt_flag_q     <= capt_event || (capt_flag_q && !(flag_clr_wr && w_data_q[1]));
      end
   end

   // Read path; registered data
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'b00;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= 2'b00;
         case (s_axi_araddr)
            TMW_ADR_CTRL_A: s_axi_rdata <= {24'h00_0000, ctrl_a_q};
            TMW_ADR_CTRL_B: s_axi_rdata <= {24'h00_0000, ctrl_b_q};
            TMW_ADR_CMP_A:  s_axi_rdata <= {16'h0000, cmp_a_buf_q};
            TMW_ADR_CMP_B:  s_axi_rdata <= {16'h0000, cmp_b_buf_q};
            TMW_ADR_CAPT:   s_axi_rdata <= {16'h0000, capture_value_q};
            TMW_ADR_COUNT:  s_axi_rdata <= {16'h0000, count_value_q};
            TMW_ADR_STATUS: s_axi_rdata <= {29'h0000_0000, up_q, capt_flag_q, overflow_flag_q};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= 2'b10;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Compare output channels and pin mux
   logic wave_a, wave_b, sel_a, sel_b;

   tmw_out_unit #(.IS_CHAN_A(1'b1)) u_out_a (
      .clk_sys_i    (clk_sys_i),
      .rst_i        (rst_i),
      .tick_i       (tick && !cnt_wr),
      .action_i     (chan_a_output_action),
      .mode_i       (waveform_mode_sel),
      .wave_i       (wave),
      .match_i      (match_a),
      .at_top_i     (at_top),
      .at_bottom_i  (at_bottom),
      .up_i         (up_q),
      .cmp_is_top_i (cmp_a_q == top_val),
      .pin_sel_o    (sel_a),
      .wave_o       (wave_a)
   );

   tmw_out_unit #(.IS_CHAN_A(1'b0)) u_out_b (
      .clk_sys_i    (clk_sys_i),
      .rst_i        (rst_i),
      .tick_i       (tick && !cnt_wr),
      .action_i     (chan_b_output_action),
      .mode_i       (waveform_mode_sel),
      .wave_i       (wave),
      .match_i      (match_b),
      .at_top_i     (at_top),
      .at_bottom_i  (at_bottom),
      .up_i         (up_q),
      .cmp_is_top_i (cmp_b_q == top_val),
      .pin_sel_o    (sel_b),
      .wave_o       (wave_b)
   );

   // compare replaces port data; driver enable is software's
   assign compare_out_a   = sel_a ? wave_a : port_a_data_i;
   assign compare_out_b   = sel_b ? wave_b : port_b_data_i;
   assign pin_sel_a_o     = sel_a;
   assign pin_sel_b_o     = sel_b;
   assign overflow_flag_o = overflow_flag_q;
endmodule
`default_nettype wire

// ---- test/tmw_pin_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// Pin side: port A data moves every cycle, port B every second, so a stale pin mux shows up
module tmw_pin_model (
   input  wire logic clk_sys_i,
   output logic      port_a_o,
   output logic      port_b_o,
   output logic      ext_o,
   output logic      cap_o
);
   logic [2:0] ph_q = 3'h0;
   always_ff @(posedge clk_sys_i) ph_q <= ph_q + 3'h1;
   assign port_a_o = ph_q[0];
   assign port_b_o = ph_q[1];
   // Slow edges on count and capture pins
   assign ext_o = ph_q[2];
   assign cap_o = ph_q[2];
endmodule
`default_nettype wire

// ---- test/tmw_timer_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
// Bus answers and pin mux, seen from the ports only
module tmw_timer_chk
   import tmw_pkg::*;
(
   input wire logic        clk_sys_i,
   input wire logic        rst_i,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        port_a_data_i,
   input wire logic        port_b_data_i,
   input wire logic        compare_out_a,
   input wire logic        compare_out_b,
   input wire logic        pin_sel_a_o,
   input wire logic        pin_sel_b_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   //////////////////////////////////////////////////////////////
   a_mux_port_a: assert property (!pin_sel_a_o |-> compare_out_a == port_a_data_i)
      else $error("pin A left port data");
   a_mux_port_b: assert property (!pin_sel_b_o |-> compare_out_b == port_b_data_i)
      else $error("pin B left port data");
   // Pin A takeover only follows a register write
   a_sel_by_write: assert property ($changed(pin_sel_a_o) |-> $past(s_axi_wvalid) || $past(s_axi_wvalid, 2))
      else $error("pin select moved without a write");
   a_rd_unmapped: assert property (s_rd_take and (s_axi_araddr > TMW_ADR_STATUS || s_axi_araddr[1:0] != 2'b00)
      |=> s_axi_rvalid && s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000) else $error("bad unmapped read");
   a_rsvd_bit_zero: assert property (s_rd_take and s_axi_araddr == TMW_ADR_CTRL_B
      |=> s_axi_rdata[31:8] == 24'h00_0000 && !s_axi_rdata[5]) else $error("reserved bit set");
   a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
      else $error("read answer late");
   a_rd_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("second read taken");
   a_rd_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer held");
   a_wr_answer: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
endmodule
bind tmw_timer_top tmw_timer_chk u_chk (.*);
`default_nettype wire

// ---- test/timer16_waveform_mode_control_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module timer16_waveform_mode_control_test;
   import tmw_pkg::*;
   logic        clk_sys_i = 0, rst_i = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, pv = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0, ext_clk_pin_i, capture_pin_i, port_a_data_i;
   logic        port_b_data_i, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        compare_out_a, compare_out_b, pin_sel_a_o, pin_sel_b_o, overflow_flag_o;
   logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdv;
   logic [3:0]  s_axi_wstrb = 4'hF, md [3] = '{4'd4, 4'd15, 4'd9};
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   int          miscompares = 0, n_tests = 0, hc, tg, i;
   tmw_timer_top dut (.*);
   tmw_pin_model u_pins (.clk_sys_i, .port_a_o(port_a_data_i), .port_b_o(port_b_data_i),
                         .ext_o(ext_clk_pin_i), .cap_o(capture_pin_i));
   initial forever #25 clk_sys_i = ~clk_sys_i;
   //////////////////////////////////////////////////////////////
   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         $display("FAIL t=%0t got %h exp %h", $time, g, e);
         miscompares++;
      end
   endtask
   // Handshake loops give up after 50 edges
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      for (i = 0; i < 50 && !(s_axi_bvalid && s_axi_bready); i++) begin
         @(posedge clk_sys_i);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      rsp = s_axi_bresp;
      if (i == 50) begin
         chk(0, 1);
         results();
      end
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys_i);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      for (i = 0; i < 50 && !(s_axi_rvalid && s_axi_rready); i++) begin
         @(posedge clk_sys_i);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      rdv = s_axi_rdata;
      rsp = s_axi_rresp;
      if (i == 50) begin
         chk(0, 1);
         results();
      end
   endtask
   // Clock on at full rate, then counter back to zero
   task automatic cfg(input logic [3:0] m, input logic [1:0] aa, input logic [1:0] ab);
      wr(TMW_ADR_CTRL_B, {27'h000_0000, m[3:2], 3'b001});
      wr(TMW_ADR_CTRL_A, {24'h00_0000, aa, ab, 2'b00, m[1:0]});
      wr(TMW_ADR_COUNT, 32'h0000_0000);
   endtask
   // High cycles and edges of pin A over n cycles
   task automatic meas(input int n);
      hc = 0;
      tg = 0;
      repeat (n) begin
         @(posedge clk_sys_i);
         hc += int'(compare_out_a);
         tg += int'(compare_out_a != pv);
         pv = compare_out_a;
      end
   endtask
   task automatic pwm(input logic [3:0] m, input logic [1:0] aa, input int n);
      cfg(m, aa, 2'b00);
      meas(1024);
      meas(n);
   endtask
   //////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      rd(TMW_ADR_CTRL_B);
      chk(rdv, 32'h0000_0000);
      wr(TMW_ADR_CTRL_B, 32'h0000_00FF);
      rd(TMW_ADR_CTRL_B);
      chk(rdv, 32'h0000_00DF);
      rd(8'h40);
      chk(32'(rsp), 32'h0000_0002);
      wr(8'h41, 32'h0000_0001);
      chk(32'(rsp), 32'h0000_0002);
      $display("test registers done");
      wr(TMW_ADR_CMP_A, 32'h0000_0010);
      cfg(4'd4, 2'b11, 2'b10);
      meas(40);
      chk({pin_sel_a_o, pin_sel_b_o, compare_out_a, compare_out_b, overflow_flag_o}, 5'b11100);
      cfg(4'd4, 2'b10, 2'b11);
      meas(40);
      chk({compare_out_a, compare_out_b}, 2'b01);
      cfg(4'd4, 2'b00, 2'b00);
      chk({pin_sel_a_o, pin_sel_b_o}, 2'b00);
      // mode 13 kept out of the table
      foreach (md[k]) begin
         cfg(md[k], 2'b01, 2'b00);
         meas(md[k] == 4'd9 ? 320 : 170);
         chk(tg inside {[9:11]}, 1);
      end
      wr(TMW_ADR_CTRL_B, 32'h0000_0012);
      meas(2560);
      chk(tg inside {[9:11]}, 1);
      $display("test toggles done");
      wr(TMW_ADR_CMP_A, 32'h0000_0080);
      pwm(4'd5, 2'b10, 512);
      chk(hc inside {[254:260]}, 1);
      pwm(4'd5, 2'b11, 512);
      chk(hc inside {[252:258]}, 1);
      pwm(4'd1, 2'b10, 1020);
      chk(hc inside {[504:518]}, 1);
      wr(TMW_ADR_CMP_A, 32'h0000_00FF);
      pwm(4'd5, 2'b10, 512);
      chk(hc, 512);
      chk(overflow_flag_o, 1);
      $display("test pwm done");
      results();
   end
   initial begin
      #2_000_000;
      chk(0, 1);
      results();
   end
endmodule
`default_nettype wire
